//--- boundary_scan_monitor.sv
// checker of test port, strap, pin and stream outputs
// assumes a bind onto boundary_scan_test_port
`timescale 1ns/10ps
`include "boundary_scan_params.svh"
module boundary_scan_monitor (
   // clocks and strap
   input wire logic clk, resetn, tck, scan_enable,
   // test port
   input wire logic tms, tdi, tdo_in, tdo_oe,
   // pins and stream
   input wire logic [`NUM_IO-1:0]  pin_oe,
   input wire logic [`GPIO_W-1:0]  gpio_in,
   input wire logic                isp_valid, isp_ready,
   input wire logic [`ISP_LEN-1:0] isp_data
);
   chk_oe_reset: assert property (@(posedge tck) disable iff (!resetn)
      tms [*5] |-> !tdo_oe) else $error("tdo driven after reset walk");
   chk_oe_entry: assert property (@(posedge tck) disable iff (!resetn)
      tdo_oe |-> !$past(tms)) else $error("shift without tms low");
   chk_oe_exit: assert property (@(posedge tck) disable iff (!resetn)
      tdo_oe && tms |=> !tdo_oe) else $error("tdo kept after shift");
   chk_oe_stay: assert property (@(posedge tck) disable iff (!resetn)
      tdo_oe && !tms |=> tdo_oe) else $error("shift left early");
   chk_oe_strap: assert property (@(posedge tck) disable iff (!resetn)
      !scan_enable [*4] |-> !tdo_oe) else $error("tdo driven when off");
   chk_gpio_zero: assert property (@(posedge clk) disable iff (!resetn)
      scan_enable [*4] |-> gpio_in == '0) else $error("gpio not zero");
   chk_gpio_pass: assert property (@(posedge clk) disable iff (!resetn)
      !scan_enable [*5] |-> gpio_in == $past({tdo_in, tdi, tms, tck}, 3))
      else $error("gpio not the test pins");
   chk_word_hold: assert property (@(posedge clk) disable iff (!resetn)
      isp_valid && !isp_ready |=> isp_valid && $stable(isp_data))
      else $error("word dropped while stalled");
   chk_reset_out: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> !isp_valid && pin_oe == '0)
      else $error("outputs not cleared");
endmodule
bind boundary_scan_test_port boundary_scan_monitor i_mon (.clk, .resetn,
   .tck, .scan_enable, .tms, .tdi, .tdo_in, .tdo_oe, .pin_oe, .gpio_in,
   .isp_valid, .isp_ready, .isp_data);

//--- boundary_scan_params.svh
// constants of the boundary-scan test port: lengths, codes, capture values
// assumes it is included by the package and by the design modules
`ifndef BOUNDARY_SCAN_PARAMS_SVH
`define BOUNDARY_SCAN_PARAMS_SVH

// instruction register length and its fixed capture pattern
`define IR_LEN          4
`define IR_CAPTURE      4'h1

// instruction opcodes
`define OP_EXTEST       4'h0
`define OP_SAMPLE       4'h1
`define OP_IDCODE       4'h2
`define OP_ISP_ENABLE   4'h8
`define OP_ISP_PROGRAM  4'h9
`define OP_ISP_DISABLE  4'ha
`define OP_BYPASS       4'hf

// device pins under boundary scan, three cells each
`define NUM_IO          8
`define CELLS_PER_PIN   3
`define BSR_LEN         24
`define CELL_IN         0
`define CELL_OUT        1
`define CELL_OE         2

// identification register; the code value is arbitrary
`define ID_LEN          32
`define ID_VALUE        32'h0a5c_3001

// programming word and its status capture positions
`define ISP_LEN         16
`define ISP_ST_ENABLED  0
`define ISP_ST_BUSY     1

// programming stream buffer
`define FIFO_DEPTH      8

// four-pin level synchroniser plus one output stage
`define GPIO_W          4

`endif

//--- boundary_scan_pkg.sv
// types of the boundary-scan test port: tap states and instructions
// assumes boundary_scan_params.svh is on the include path
`include "boundary_scan_params.svh"

package boundary_scan_pkg;

   // gray codes along the usual path through the controller
   typedef enum logic [3:0] {
      tap_reset     = 4'h0,
      tap_idle      = 4'h1,
      tap_sel_dr    = 4'h3,
      tap_cap_dr    = 4'h2,
      tap_shift_dr  = 4'h6,
      tap_exit1_dr  = 4'h7,
      tap_pause_dr  = 4'h5,
      tap_exit2_dr  = 4'h4,
      tap_upd_dr    = 4'hc,
      tap_sel_ir    = 4'hd,
      tap_cap_ir    = 4'hf,
      tap_shift_ir  = 4'he,
      tap_exit1_ir  = 4'ha,
      tap_pause_ir  = 4'hb,
      tap_exit2_ir  = 4'h9,
      tap_upd_ir    = 4'h8
   } tap_state_e;

   typedef enum logic [`IR_LEN-1:0] {
      instr_extest      = `OP_EXTEST,
      instr_sample      = `OP_SAMPLE,
      instr_idcode      = `OP_IDCODE,
      instr_isp_enable  = `OP_ISP_ENABLE,
      instr_isp_program = `OP_ISP_PROGRAM,
      instr_isp_disable = `OP_ISP_DISABLE,
      instr_bypass      = `OP_BYPASS
   } instr_e;

endpackage

//--- boundary_scan_test_port.sv
// boundary-scan test access port with pin scan and programming stream
// assumes tck from the scan controller, clk for the device core side
//
// Overview of operation
// - standard tap controller, instruction and data registers
// - sample captures pin levels, core keeps running
// - preloaded pattern waits for an output-driving instruction
// - extest drives pins from update cells, captures inputs
// - bypass puts one stage between tdi and tdo
// - idcode shifts identification value out on tdo
// - scan disabled releases test pins as user inputs
// - programming instructions load words through the port
// - four user pins become the test port
`timescale 1ns/10ps

`include "boundary_scan_params.svh"
module boundary_scan_test_port (
   // system side
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // test port pins
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   input  wire logic                  tdo_in,
   output logic                       tdo_out,
   output logic                       tdo_oe,
   // configuration strap
   input  wire logic                  scan_enable,
   // device pins and the core behind them
   input  wire logic [`NUM_IO-1:0]    pin_in,
   input  wire logic [`NUM_IO-1:0]    core_out,
   input  wire logic [`NUM_IO-1:0]    core_oe,
   output logic      [`NUM_IO-1:0]    pin_out,
   output logic      [`NUM_IO-1:0]    pin_oe,
   // test port pins seen as user inputs
   output logic      [`GPIO_W-1:0]    gpio_in,
   // programming stream
   output logic                       isp_mode,
   output logic                       isp_valid,
   output logic      [`ISP_LEN-1:0]   isp_data,
   input  wire logic                  isp_ready
);

   // unknown opcodes fall back to bypass
   function automatic boundary_scan_pkg::instr_e decode_instr(
      input logic [`IR_LEN-1:0] code);
      boundary_scan_pkg::instr_e ins;
      ins = boundary_scan_pkg::instr_bypass;
      unique case (code)
         `OP_EXTEST:      ins = boundary_scan_pkg::instr_extest;
         `OP_SAMPLE:      ins = boundary_scan_pkg::instr_sample;
         `OP_IDCODE:      ins = boundary_scan_pkg::instr_idcode;
         `OP_ISP_ENABLE:  ins = boundary_scan_pkg::instr_isp_enable;
         `OP_ISP_PROGRAM: ins = boundary_scan_pkg::instr_isp_program;
         `OP_ISP_DISABLE: ins = boundary_scan_pkg::instr_isp_disable;
         default:         ins = boundary_scan_pkg::instr_bypass;
      endcase
      return ins;
   endfunction

   // ---- tck domain ----
   boundary_scan_pkg::tap_state_e tap_state_reg;
   boundary_scan_pkg::tap_state_e tap_state_next;
   boundary_scan_pkg::instr_e     ir_reg;
   logic [`IR_LEN-1:0]            ir_shift_reg;
   logic                          bypass_reg;
   logic [`ID_LEN-1:0]            id_shift_reg;
   logic [`BSR_LEN-1:0]           bsr_shift_reg;
   logic [`NUM_IO-1:0]            upd_out_reg;
   logic [`NUM_IO-1:0]            upd_oe_reg;
   logic                          upd_tgl_reg;
   logic [`ISP_LEN-1:0]           isp_shift_reg;
   logic [`ISP_LEN-1:0]           isp_word_reg;
   logic                          isp_en_reg;
   logic                          isp_pend_reg;
   logic                          req_tgl_reg;
   logic                          ack_t1_reg;
   logic                          ack_t2_reg;
   logic                          ack_seen_reg;
   logic                          en_t1_reg;
   logic                          en_t2_reg;
   logic [`NUM_IO-1:0]            pin_t1_reg;
   logic [`NUM_IO-1:0]            pin_t2_reg;
   logic                          tdo_next;
   logic                          tdo_out_reg;
   logic                          tdo_oe_reg;
   logic                          pin_scan;

   // ---- clk domain ----
   logic                          en_c1_reg;
   logic                          en_c2_reg;
   logic                          ext_c1_reg;
   logic                          ext_c2_reg;
   logic                          isp_c1_reg;
   logic                          isp_c2_reg;
   logic                          upd_c1_reg;
   logic                          upd_c2_reg;
   logic                          upd_c3_reg;
   logic [`NUM_IO-1:0]            upd_out_c_reg;
   logic [`NUM_IO-1:0]            upd_oe_c_reg;
   logic                          req_c1_reg;
   logic                          req_c2_reg;
   logic                          req_c3_reg;
   logic                          push_pend_reg;
   logic                          ack_tgl_reg;
   logic [`GPIO_W-1:0]            gpio_c1_reg;
   logic [`GPIO_W-1:0]            gpio_c2_reg;
   logic [`GPIO_W-1:0]            gpio_in_reg;
   logic [`NUM_IO-1:0]            pin_out_reg;
   logic [`NUM_IO-1:0]            pin_oe_reg;
   logic                          fifo_in_ready;

   assign pin_scan = (ir_reg == boundary_scan_pkg::instr_sample) ||
                     (ir_reg == boundary_scan_pkg::instr_extest);

   // strap and pin levels reach the tap only through two flops
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         en_t1_reg  <= 1'b0;
         en_t2_reg  <= 1'b0;
         pin_t1_reg <= '0;
         pin_t2_reg <= '0;
         ack_t1_reg <= 1'b0;
         ack_t2_reg <= 1'b0;
      end else begin
         en_t1_reg  <= scan_enable;
         en_t2_reg  <= en_t1_reg;
         pin_t1_reg <= pin_in;
         pin_t2_reg <= pin_t1_reg;
         ack_t1_reg <= ack_tgl_reg;
         ack_t2_reg <= ack_t1_reg;
      end
   end

   always_comb begin
      tap_state_next = tap_state_reg;
      unique case (tap_state_reg)
         boundary_scan_pkg::tap_reset:    tap_state_next = tms ?
            boundary_scan_pkg::tap_reset : boundary_scan_pkg::tap_idle;
         boundary_scan_pkg::tap_idle:     tap_state_next = tms ?
            boundary_scan_pkg::tap_sel_dr : boundary_scan_pkg::tap_idle;
         boundary_scan_pkg::tap_sel_dr:   tap_state_next = tms ?
            boundary_scan_pkg::tap_sel_ir : boundary_scan_pkg::tap_cap_dr;
         boundary_scan_pkg::tap_cap_dr:   tap_state_next = tms ?
            boundary_scan_pkg::tap_exit1_dr : boundary_scan_pkg::tap_shift_dr;
         boundary_scan_pkg::tap_shift_dr: tap_state_next = tms ?
            boundary_scan_pkg::tap_exit1_dr : boundary_scan_pkg::tap_shift_dr;
         boundary_scan_pkg::tap_exit1_dr: tap_state_next = tms ?
            boundary_scan_pkg::tap_upd_dr : boundary_scan_pkg::tap_pause_dr;
         boundary_scan_pkg::tap_pause_dr: tap_state_next = tms ?
            boundary_scan_pkg::tap_exit2_dr : boundary_scan_pkg::tap_pause_dr;
         boundary_scan_pkg::tap_exit2_dr: tap_state_next = tms ?
            boundary_scan_pkg::tap_upd_dr : boundary_scan_pkg::tap_shift_dr;
         boundary_scan_pkg::tap_upd_dr:   tap_state_next = tms ?
            boundary_scan_pkg::tap_sel_dr : boundary_scan_pkg::tap_idle;
         boundary_scan_pkg::tap_sel_ir:   tap_state_next = tms ?
            boundary_scan_pkg::tap_reset : boundary_scan_pkg::tap_cap_ir;
         boundary_scan_pkg::tap_cap_ir:   tap_state_next = tms ?
            boundary_scan_pkg::tap_exit1_ir : boundary_scan_pkg::tap_shift_ir;
         boundary_scan_pkg::tap_shift_ir: tap_state_next = tms ?
            boundary_scan_pkg::tap_exit1_ir : boundary_scan_pkg::tap_shift_ir;
         boundary_scan_pkg::tap_exit1_ir: tap_state_next = tms ?
            boundary_scan_pkg::tap_upd_ir : boundary_scan_pkg::tap_pause_ir;
         boundary_scan_pkg::tap_pause_ir: tap_state_next = tms ?
            boundary_scan_pkg::tap_exit2_ir : boundary_scan_pkg::tap_pause_ir;
         boundary_scan_pkg::tap_exit2_ir: tap_state_next = tms ?
            boundary_scan_pkg::tap_upd_ir : boundary_scan_pkg::tap_shift_ir;
         boundary_scan_pkg::tap_upd_ir:   tap_state_next = tms ?
            boundary_scan_pkg::tap_sel_dr : boundary_scan_pkg::tap_idle;
      endcase
   end

   // a disabled port holds the controller in reset
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         tap_state_reg <= boundary_scan_pkg::tap_reset;
      end else if (!en_t2_reg) begin
         tap_state_reg <= boundary_scan_pkg::tap_reset;
      end else begin
         tap_state_reg <= tap_state_next;
      end
   end

   // instruction register, lsb first
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         ir_shift_reg <= '0;
         ir_reg       <= boundary_scan_pkg::instr_idcode;
      end else begin
         unique case (tap_state_reg)
            boundary_scan_pkg::tap_reset:
               ir_reg <= boundary_scan_pkg::instr_idcode;
            boundary_scan_pkg::tap_cap_ir:
               ir_shift_reg <= `IR_CAPTURE;
            boundary_scan_pkg::tap_shift_ir:
               ir_shift_reg <= {tdi, ir_shift_reg[`IR_LEN-1:1]};
            boundary_scan_pkg::tap_upd_ir:
               ir_reg <= decode_instr(ir_shift_reg);
            default: ;
         endcase
      end
   end

   // bypass, identification and boundary shift paths
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         bypass_reg    <= 1'b0;
         id_shift_reg  <= '0;
         bsr_shift_reg <= '0;
      end else if (tap_state_reg == boundary_scan_pkg::tap_cap_dr) begin
         bypass_reg   <= 1'b0;
         id_shift_reg <= `ID_VALUE;
         if (pin_scan) begin
            for (int i = 0; i < `NUM_IO; i++) begin
               bsr_shift_reg[i*`CELLS_PER_PIN + `CELL_IN] <=
                  pin_t2_reg[i];
               bsr_shift_reg[i*`CELLS_PER_PIN + `CELL_OUT] <= upd_out_reg[i];
               bsr_shift_reg[i*`CELLS_PER_PIN + `CELL_OE] <= upd_oe_reg[i];
            end
         end
      end else if (tap_state_reg == boundary_scan_pkg::tap_shift_dr) begin
         bypass_reg   <= tdi;
         id_shift_reg <= {tdi, id_shift_reg[`ID_LEN-1:1]};
         if (pin_scan) begin
            bsr_shift_reg <= {tdi, bsr_shift_reg[`BSR_LEN-1:1]};
         end
      end
   end

   // update cells keep a preloaded pattern until extest drives it
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         upd_out_reg <= '0;
         upd_oe_reg  <= '0;
         upd_tgl_reg <= 1'b0;
      end else if (tap_state_reg == boundary_scan_pkg::tap_upd_dr &&
                   pin_scan) begin
         for (int i = 0; i < `NUM_IO; i++) begin
            upd_out_reg[i] <=
               bsr_shift_reg[i*`CELLS_PER_PIN + `CELL_OUT];
            upd_oe_reg[i]  <= bsr_shift_reg[i*`CELLS_PER_PIN + `CELL_OE];
         end
         upd_tgl_reg <= !upd_tgl_reg;
      end
   end

   // programming mode entry and exit
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         isp_en_reg <= 1'b0;
      end else if (tap_state_reg == boundary_scan_pkg::tap_reset) begin
         isp_en_reg <= 1'b0;
      end else if (tap_state_reg == boundary_scan_pkg::tap_upd_ir) begin
         if (decode_instr(ir_shift_reg) ==
             boundary_scan_pkg::instr_isp_enable) begin
            isp_en_reg <= 1'b1;
         end else if (decode_instr(ir_shift_reg) ==
                      boundary_scan_pkg::instr_isp_disable) begin
            isp_en_reg <= 1'b0;
         end
      end
   end

   // programming word: status on capture, handed over on update
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         isp_shift_reg <= '0;
         isp_word_reg  <= '0;
         isp_pend_reg  <= 1'b0;
         req_tgl_reg   <= 1'b0;
         ack_seen_reg  <= 1'b0;
      end else begin
         if (ir_reg == boundary_scan_pkg::instr_isp_program) begin
            if (tap_state_reg == boundary_scan_pkg::tap_cap_dr) begin
               isp_shift_reg <= '0;
               isp_shift_reg[`ISP_ST_ENABLED] <= isp_en_reg;
               // an acknowledge already synced means the word is taken
               isp_shift_reg[`ISP_ST_BUSY]    <= isp_pend_reg &&
                  (ack_t2_reg == ack_seen_reg);
            end else if (tap_state_reg == boundary_scan_pkg::tap_shift_dr) begin
               isp_shift_reg <= {tdi, isp_shift_reg[`ISP_LEN-1:1]};
            end
         end
         // a word updated while the previous one is pending is dropped
         if (tap_state_reg == boundary_scan_pkg::tap_upd_dr &&
             ir_reg == boundary_scan_pkg::instr_isp_program &&
             isp_en_reg && !isp_pend_reg) begin
            isp_word_reg <= isp_shift_reg;
            isp_pend_reg <= 1'b1;
            req_tgl_reg  <= !req_tgl_reg;
         end else if (ack_t2_reg != ack_seen_reg) begin
            isp_pend_reg <= 1'b0;
            ack_seen_reg <= ack_t2_reg;
         end
      end
   end

   always_comb begin
      tdo_next = 1'b0;
      if (tap_state_reg == boundary_scan_pkg::tap_shift_ir) begin
         tdo_next = ir_shift_reg[0];
      end else begin
         unique case (ir_reg)
            boundary_scan_pkg::instr_extest:      tdo_next = bsr_shift_reg[0];
            boundary_scan_pkg::instr_sample:      tdo_next = bsr_shift_reg[0];
            boundary_scan_pkg::instr_idcode:      tdo_next = id_shift_reg[0];
            boundary_scan_pkg::instr_isp_program: tdo_next = isp_shift_reg[0];
            boundary_scan_pkg::instr_isp_enable:  tdo_next = bypass_reg;
            boundary_scan_pkg::instr_isp_disable: tdo_next = bypass_reg;
            boundary_scan_pkg::instr_bypass:      tdo_next = bypass_reg;
         endcase
      end
   end

   // tdo driven only while shifting, changed on the falling edge
   always_ff @(negedge tck or negedge resetn) begin
      if (!resetn) begin
         tdo_out_reg <= 1'b0;
         tdo_oe_reg  <= 1'b0;
      end else begin
         tdo_out_reg <= tdo_next;
         tdo_oe_reg  <= (tap_state_reg == boundary_scan_pkg::tap_shift_dr) ||
                        (tap_state_reg == boundary_scan_pkg::tap_shift_ir);
      end
   end

   // levels into the clk domain
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en_c1_reg   <= 1'b0;
         en_c2_reg   <= 1'b0;
         ext_c1_reg  <= 1'b0;
         ext_c2_reg  <= 1'b0;
         isp_c1_reg  <= 1'b0;
         isp_c2_reg  <= 1'b0;
         gpio_c1_reg <= '0;
         gpio_c2_reg <= '0;
         gpio_in_reg <= '0;
      end else begin
         en_c1_reg   <= scan_enable;
         en_c2_reg   <= en_c1_reg;
         ext_c1_reg  <= ir_reg == boundary_scan_pkg::instr_extest;
         ext_c2_reg  <= ext_c1_reg;
         isp_c1_reg  <= isp_en_reg;
         isp_c2_reg  <= isp_c1_reg;
         gpio_c1_reg <= {tdo_in, tdi, tms, tck};
         gpio_c2_reg <= gpio_c1_reg;
         gpio_in_reg <= en_c2_reg ? '0 : gpio_c2_reg;
      end
   end

   // update cells cross on a toggle; they hold still for a whole scan
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         upd_c1_reg    <= 1'b0;
         upd_c2_reg    <= 1'b0;
         upd_c3_reg    <= 1'b0;
         upd_out_c_reg <= '0;
         upd_oe_c_reg  <= '0;
      end else begin
         upd_c1_reg <= upd_tgl_reg;
         upd_c2_reg <= upd_c1_reg;
         upd_c3_reg <= upd_c2_reg;
         if (upd_c2_reg != upd_c3_reg) begin
            upd_out_c_reg <= upd_out_reg;
            upd_oe_c_reg  <= upd_oe_reg;
         end
      end
   end

   // pins follow the core except under extest
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_out_reg <= '0;
         pin_oe_reg  <= '0;
      end else if (ext_c2_reg) begin
         pin_out_reg <= upd_out_c_reg;
         pin_oe_reg  <= upd_oe_c_reg;
      end else begin
         pin_out_reg <= core_out;
         pin_oe_reg  <= core_oe;
      end
   end

   // programming word handshake into the buffer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_c1_reg    <= 1'b0;
         req_c2_reg    <= 1'b0;
         req_c3_reg    <= 1'b0;
         push_pend_reg <= 1'b0;
         ack_tgl_reg   <= 1'b0;
      end else begin
         req_c1_reg <= req_tgl_reg;
         req_c2_reg <= req_c1_reg;
         req_c3_reg <= req_c2_reg;
         if (req_c2_reg != req_c3_reg) begin
            push_pend_reg <= 1'b1;
         end else if (push_pend_reg && fifo_in_ready) begin
            push_pend_reg <= 1'b0;
            ack_tgl_reg   <= !ack_tgl_reg;
         end
      end
   end

   stream_fifo #(
      .WIDTH (`ISP_LEN),
      .DEPTH (`FIFO_DEPTH)
   ) isp_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (push_pend_reg),
      .in_data   (isp_word_reg),
      .in_ready  (fifo_in_ready),
      .out_valid (isp_valid),
      .out_data  (isp_data),
      .out_ready (isp_ready)
   );

   assign tdo_out  = tdo_out_reg;
   assign tdo_oe   = tdo_oe_reg;
   assign pin_out  = pin_out_reg;
   assign pin_oe   = pin_oe_reg;
   assign gpio_in  = gpio_in_reg;
   assign isp_mode = isp_c2_reg;

endmodule

//--- boundary_scan_test_port_tb.sv
// self-checking bench of the boundary-scan test port
// assumes scan_host on the link, the bench drains the stream
`timescale 1ns/10ps
`include "boundary_scan_params.svh"
module boundary_scan_test_port_tb;
   logic clk, resetn, tdo_out, tdo_oe, ext_tdo, scan_enable, isp_ready;
   logic tck, tms, tdi, tdo_in, isp_mode, isp_valid, q1;
   logic [`NUM_IO-1:0] pin_in, core_out, core_oe, pin_out, pin_oe;
   logic [`GPIO_W-1:0] gpio_in;
   logic [`ISP_LEN-1:0] isp_data;
   logic [31:0] q, d;
   logic [23:0] upd;
   logic [15:0] words[$];
   logic [3:0] ops[2] = '{`OP_BYPASS, 4'h5};
   int seed = 32'h23ed986b;
   int err_count = 0, n_compared = 0, got = 0;
   assign tdo_in = tdo_oe ? tdo_out : ext_tdo;
   boundary_scan_test_port i_dut (.*);
   scan_host i_host (.tck, .tms, .tdi, .tdo(tdo_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      err_count++;
      test_done;
   end
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   // idle to shift, n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] di);
      #1 q = '0;
      repeat (ir + 1) i_host.step(1'b1, 1'b0, q1);
      repeat (2) i_host.step(1'b0, 1'b0, q1);
      for (int i = 0; i < n; i++) begin
         i_host.step(i == n - 1, di[i], q1);
         q[i] = q1;
      end
      i_host.step(1'b1, 1'b0, q1);
      i_host.step(1'b0, 1'b0, q1);
   endtask
   task automatic load(input logic [3:0] op);
      scan(1'b1, 4, {28'h0, op});
      check(q, {28'h0, `IR_CAPTURE});
      repeat (8) @(posedge clk);
   endtask
   function automatic logic [31:0] cells(logic [7:0] p, logic [23:0] u);
      for (int i = 0; i < `NUM_IO; i++)
         u[3*i+`CELL_IN] = p[i];
      return {8'h0, u};
   endfunction
   function automatic logic [31:0] drive(logic [23:0] u);
      drive = '0;
      for (int i = 0; i < `NUM_IO; i++) begin
         drive[i] = u[3*i+`CELL_OUT];
         drive[i+8] = u[3*i+`CELL_OE];
      end
   endfunction
   initial begin
      {resetn, scan_enable, isp_ready, ext_tdo, upd} = '0;
      {pin_in, core_out, core_oe} = '0;
      scan_enable = 1'b1;
      repeat (3) i_host.step(1'b1, 1'b0, q1);
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      ext_tdo <= 1'b1;
      {core_out, core_oe, pin_in} <= 24'($random(seed));
      #1 repeat (5) i_host.step(1'b1, 1'b0, q1);
      i_host.step(1'b0, 1'b0, q1);
      scan(1'b0, 32, '0);
      check(q, `ID_VALUE);
      foreach (ops[k]) begin
         load(ops[k]);
         d = $random(seed);
         scan(1'b0, 8, d);
         check(q, {24'h0, d[6:0], 1'b0});
      end
      load(`OP_IDCODE);
      scan(1'b0, 32, $random(seed));
      check(q, `ID_VALUE);
      load(`OP_SAMPLE);
      d = $random(seed);
      scan(1'b0, 24, d);
      check(q, cells(pin_in, upd));
      upd = d[23:0];
      repeat (8) @(posedge clk);
      check({pin_oe, pin_out}, {core_oe, core_out});
      load(`OP_EXTEST);
      check({pin_oe, pin_out}, drive(upd));
      pin_in <= 8'($random(seed));
      d = $random(seed);
      scan(1'b0, 24, d);
      check(q, cells(pin_in, upd));
      upd = d[23:0];
      repeat (8) @(posedge clk);
      check({pin_oe, pin_out}, drive(upd));
      load(`OP_ISP_ENABLE);
      check(isp_mode, 1'b1);
      load(`OP_ISP_PROGRAM);
      for (int k = 0; k < 11; k++) begin
         d = $random(seed);
         scan(1'b0, 16, d);
         check(q[1:0], k < 10 ? 2'h1 : 2'h3);
         if (k < 10)
            words.push_back(d[15:0]);
         repeat (12) @(posedge clk);
      end
      isp_ready <= 1'b1;
      repeat (100) begin
         @(posedge clk);
         if (isp_valid === 1'b1) begin
            check(isp_data, words[got]);
            got++;
         end
      end
      check(got, 10);
      load(`OP_ISP_DISABLE);
      check(isp_mode, 1'b0);
      scan_enable <= 1'b0;
      ext_tdo <= 1'b0;
      @(posedge clk);
      #1 repeat (6) i_host.step(1'($random(seed)), 1'($random(seed)), q1);
      repeat (6) @(posedge clk);
      check({tdo_oe, gpio_in}, {1'b0, ext_tdo, tdi, tms, tck});
      test_done;
   end
endmodule

//--- scan_host.sv
// scan controller model for the test port
// assumes one call of step per test clock period
`timescale 1ns/10ps
module scan_host (
   // test port pins
   output logic tck, tms, tdi,
   input wire logic tdo
);
   initial {tck, tms, tdi} = 3'b010;
   // tck rests low outside frames
   task automatic step(input logic m, d, output logic q);
      tms = m;
      tdi = d;
      #7.5 tck = 1'b1;
      q = tdo;
      #7.5 tck = 1'b0;
   endtask
endmodule

//--- stream_fifo.sv
// synchronous valid/ready fifo with a registered output stage
// assumes one clock, active-low async reset, depth a power of two
`timescale 1ns/10ps

module stream_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             push;
   logic             pop;

   assign in_ready  = count_reg != (AW+1)'(DEPTH);
   assign push      = in_valid && in_ready;
   assign pop       = (count_reg != '0) && (!out_valid_reg || out_ready);
   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end else if (pop) begin
         out_valid_reg <= 1'b1;
         out_data_reg  <= mem[rd_ptr_reg];
      end else if (out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end

endmodule
